// *** adc_ctrl_pkg.sv ***
// constants shared by the converter control block
`default_nettype none
package adc_ctrl_pkg;

    // register offsets on the plain register port
    localparam logic [2:0] OFS_CONTROL     = 3'h0;
    localparam logic [2:0] OFS_RESULT_HIGH = 3'h1;
    localparam logic [2:0] OFS_IRQ_STATUS  = 3'h2;
    localparam logic [2:0] OFS_IRQ_ENABLE  = 3'h3;
    localparam logic [2:0] OFS_IRQ_CLEAR   = 3'h4;
    localparam logic [2:0] OFS_WAKE_CFG    = 3'h5;

    // control register fields
    localparam int CTL_CHAN_LSB   = 0;
    localparam int CTL_CHAN_MSB   = 1;
    localparam int CTL_START      = 3;
    localparam int CTL_DONE       = 4;
    localparam int CTL_EXT_EN     = 5;
    localparam int CTL_RES_LSB    = 6;
    localparam int CTL_RES_MSB    = 7;

    // interrupt status / enable / clear layout
    localparam int IRQ_DONE       = 0;
    localparam int IRQ_EXT_START  = 1;
    localparam int IRQ_BITS       = 2;

    // wake configuration fields
    localparam int WAKE_EN        = 0;

    // reset values
    localparam logic [7:0] CONTROL_RESET    = 8'h00;
    localparam logic [7:0] RESULT_RESET     = 8'h00;
    localparam logic [1:0] IRQ_RESET        = 2'h0;

    // conversion timing in machine cycles
    localparam int RESULT_BITS    = 10;
    localparam int INIT_CYCLES    = 2;
    localparam int SAMPLE_CYCLES  = 8;
    localparam int TRIAL_CYCLES   = 4;
    localparam int CONV_CYCLES    = 52;
    localparam int FINISH_CYCLES  = CONV_CYCLES - INIT_CYCLES - SAMPLE_CYCLES
                                    - TRIAL_CYCLES * RESULT_BITS;

    // first trial code: only the top bit set
    localparam logic [9:0] SAR_FIRST_TRIAL = 10'h200;

    // core clocks per machine cycle
    localparam int MC_CLOCKS      = 4;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_INIT,
        PH_SAMPLE,
        PH_TRIAL,
        PH_FINISH
    } phase_e;

endpackage
`default_nettype wire

// *** sync_2ff.sv ***
// two flip-flop synchroniser for asynchronous levels
`default_nettype none
module sync_2ff #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             rstn,
    // levels
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] meta;

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta    <= '0;
            syncOut <= '0;
        end
        else
        begin
            meta    <= asyncIn;
            syncOut <= meta;
        end
    end

endmodule
`default_nettype wire

// *** mcycle_timer.sv ***
// machine cycle divider giving a one-clock pulse at each cycle end
`default_nettype none
module mcycle_timer #(
    parameter int CLOCKS = 4
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rstn,
    // machine cycle end pulse
    output logic      mcEnd
);

    localparam int CW = (CLOCKS > 1) ? $clog2(CLOCKS) : 1;
    localparam logic [CW-1:0] LAST = CW'(CLOCKS - 1);

    logic [CW-1:0] count;
    wire           atLast = (count == LAST);

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            count <= '0;
            mcEnd <= 1'b0;
        end
        else
        begin
            count <= atLast ? '0 : count + CW'(1);
            mcEnd <= atLast;
        end
    end

endmodule
`default_nettype wire

// *** sar_adc_conversion_control.sv ***
// successive-approximation converter sequencer with registers and interrupt
//
// Design decisions made here: strobed register access and the register addresses.
`default_nettype none
module sar_adc_conversion_control
    import adc_ctrl_pkg::*;
#(
    parameter int MC_CLKS = MC_CLOCKS
) (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rstn,
    // register port
    input  wire logic [2:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    output logic      [7:0] regRdData,
    // external start pin
    input  wire logic       externalStartPin,
    // analog front end
    input  wire logic       compGreater,
    output logic      [9:0] dacCode,
    output logic            sampling,
    output logic      [1:0] channelSelect,
    // power management
    input  wire logic       powerDown,
    input  wire logic       clockFromRc,
    output logic            wakeRequest,
    // status and interrupt
    output logic            convBusy,
    output logic            irq
);

    // machine cycle timing
    logic mcEnd;

    mcycle_timer #(
        .CLOCKS (MC_CLKS)
    ) u_mcycle (
        .mclk   (mclk),
        .rstn   (rstn),
        .mcEnd  (mcEnd)
    );

    // pin and comparator synchronisation
    logic [1:0] syncedIn;

    sync_2ff #(
        .WIDTH   (2)
    ) u_sync (
        .mclk    (mclk),
        .rstn    (rstn),
        .asyncIn ({compGreater, externalStartPin}),
        .syncOut (syncedIn)
    );

    wire pinLevel   = syncedIn[0];
    wire compLevel  = syncedIn[1];

    // register state
    logic [1:0]          chanSel;
    logic                extEnable;
    logic                startCmd;
    logic                busyFlag;
    logic                doneFlag;
    logic [1:0]          resultLow;
    logic [7:0]          resultHigh;
    logic [IRQ_BITS-1:0] irqStatus;
    logic [IRQ_BITS-1:0] irqEnable;
    logic                wakeEnable;

    // sequencer state
    phase_e      phase;
    phase_e      next_phase;
    logic [3:0]  phaseCnt;
    logic [3:0]  next_phaseCnt;
    logic [3:0]  bitIdx;
    logic [3:0]  next_bitIdx;
    logic [9:0]  sar;
    logic [9:0]  next_sar;
    logic        pinAtEnd;

    // register decode
    wire selControl = (regAddr == OFS_CONTROL);
    wire selResult  = (regAddr == OFS_RESULT_HIGH);
    wire selStatus  = (regAddr == OFS_IRQ_STATUS);
    wire selEnable  = (regAddr == OFS_IRQ_ENABLE);
    wire selClear   = (regAddr == OFS_IRQ_CLEAR);
    wire selWake    = (regAddr == OFS_WAKE_CFG);

    wire wrControl  = regWrite && selControl;
    wire wrEnable   = regWrite && selEnable;
    wire wrClear    = regWrite && selClear;
    wire wrWake     = regWrite && selWake;

    // start sources
    wire pinRise    = mcEnd && pinLevel && !pinAtEnd;
    wire extTrigger = extEnable && pinRise;
    wire swTrigger  = startCmd;
    wire idle       = (phase == PH_IDLE);
    wire launch     = idle && mcEnd && (swTrigger || extTrigger);

    // phase boundaries
    localparam logic [3:0] INIT_LAST   = 4'(INIT_CYCLES - 1);
    localparam logic [3:0] SAMPLE_LAST = 4'(SAMPLE_CYCLES - 1);
    localparam logic [3:0] TRIAL_LAST  = 4'(TRIAL_CYCLES - 1);
    localparam logic [3:0] FINISH_LAST = 4'(FINISH_CYCLES - 1);
    localparam logic [3:0] TOP_BIT     = 4'(RESULT_BITS - 1);

    wire phaseLast =
        (phase == PH_INIT   && phaseCnt == INIT_LAST)   ||
        (phase == PH_SAMPLE && phaseCnt == SAMPLE_LAST) ||
        (phase == PH_TRIAL  && phaseCnt == TRIAL_LAST)  ||
        (phase == PH_FINISH && phaseCnt == FINISH_LAST);

    wire [9:0] trialMask = 10'h001 << bitIdx;
    wire [9:0] lowerMask = 10'h001 << (bitIdx - 4'(1));

    wire busySet     = mcEnd && (phase == PH_INIT) && (phaseCnt == 4'h0);
    wire convDone    = mcEnd && (phase == PH_FINISH) && phaseLast;
    wire sampleStart = mcEnd && (phase == PH_INIT) && phaseLast;
    wire sampleStop  = mcEnd && (phase == PH_SAMPLE) && phaseLast;

    // sequencer next state
    always_comb
    begin
        next_phase    = phase;
        next_phaseCnt = phaseCnt;
        next_bitIdx   = bitIdx;
        next_sar      = sar;
        if (launch)
        begin
            next_phase    = PH_INIT;
            next_phaseCnt = 4'h0;
        end
        else if (mcEnd && !idle)
        begin
            next_phaseCnt = phaseLast ? 4'h0 : phaseCnt + 4'(1);
            case (phase)
                PH_INIT:
                begin
                    if (phaseLast)
                    begin
                        next_phase = PH_SAMPLE;
                    end
                end
                PH_SAMPLE:
                begin
                    if (phaseLast)
                    begin
                        next_phase  = PH_TRIAL;
                        next_sar    = SAR_FIRST_TRIAL;
                        next_bitIdx = TOP_BIT;
                    end
                end
                PH_TRIAL:
                begin
                    if (phaseLast)
                    begin
                        if (!compLevel)
                        begin
                            next_sar = sar & ~trialMask;
                        end
                        if (bitIdx == 4'h0)
                        begin
                            next_phase = PH_FINISH;
                        end
                        else
                        begin
                            next_bitIdx = bitIdx - 4'(1);
                            next_sar    = (compLevel ? sar : (sar & ~trialMask))
                                          | lowerMask;
                        end
                    end
                end
                PH_FINISH:
                begin
                    if (phaseLast)
                    begin
                        next_phase = PH_IDLE;
                    end
                end
                default:
                begin
                    next_phase    = PH_IDLE;
                    next_phaseCnt = 4'h0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            phase    <= PH_IDLE;
            phaseCnt <= 4'h0;
            bitIdx   <= 4'h0;
            sar      <= 10'h000;
        end
        else
        begin
            phase    <= next_phase;
            phaseCnt <= next_phaseCnt;
            bitIdx   <= next_bitIdx;
            sar      <= next_sar;
        end
    end

    // pin level held at each machine cycle end for edge detection
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            pinAtEnd <= 1'b1;
        end
        else if (mcEnd)
        begin
            pinAtEnd <= pinLevel;
        end
    end

    // command flop: set by writes, consumed at launch; ignored while busy
    wire startWrite = wrControl && regWrData[CTL_START];

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            startCmd <= 1'b0;
        end
        else if (startWrite && idle && !launch)
        begin
            startCmd <= 1'b1;
        end
        else if (launch || !idle)
        begin
            startCmd <= 1'b0;
        end
    end

    // busy status flag returned on reads
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            busyFlag <= 1'b0;
        end
        else if (busySet)
        begin
            busyFlag <= 1'b1;
        end
        else if (convDone)
        begin
            busyFlag <= 1'b0;
        end
    end

    // done flag: hardware set wins over a software clear
    wire doneClear = wrControl && !regWrData[CTL_DONE];

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            doneFlag <= CONTROL_RESET[CTL_DONE];
        end
        else if (convDone)
        begin
            doneFlag <= 1'b1;
        end
        else if (doneClear)
        begin
            doneFlag <= 1'b0;
        end
    end

    // result capture
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            resultHigh <= RESULT_RESET;
            resultLow  <= CONTROL_RESET[CTL_RES_MSB:CTL_RES_LSB];
        end
        else if (convDone)
        begin
            resultHigh <= sar[9:2];
            resultLow  <= sar[1:0];
        end
    end

    // software configuration
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            chanSel    <= CONTROL_RESET[CTL_CHAN_MSB:CTL_CHAN_LSB];
            extEnable  <= CONTROL_RESET[CTL_EXT_EN];
            irqEnable  <= IRQ_RESET;
            wakeEnable <= 1'b0;
        end
        else
        begin
            if (wrControl)
            begin
                chanSel   <= regWrData[CTL_CHAN_MSB:CTL_CHAN_LSB];
                extEnable <= regWrData[CTL_EXT_EN];
            end
            if (wrEnable)
            begin
                irqEnable <= regWrData[IRQ_BITS-1:0];
            end
            if (wrWake)
            begin
                wakeEnable <= regWrData[WAKE_EN];
            end
        end
    end

    // sticky interrupt status, set wins over clear
    wire [IRQ_BITS-1:0] irqEvents = {launch && extTrigger && !swTrigger, convDone};
    wire [IRQ_BITS-1:0] irqClear  = wrClear ? regWrData[IRQ_BITS-1:0] : '0;
    wire [IRQ_BITS-1:0] next_irqStatus = irqEvents | (irqStatus & ~irqClear);

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            irqStatus <= IRQ_RESET;
        end
        else
        begin
            irqStatus <= next_irqStatus;
        end
    end

    // read mux
    wire [7:0] controlView = {resultLow, extEnable, doneFlag, busyFlag, 1'b0, chanSel};
    wire [7:0] readMux =
        selControl ? controlView :
        selResult  ? resultHigh  :
        selStatus  ? {6'h00, irqStatus} :
        selEnable  ? {6'h00, irqEnable} :
        selWake    ? {7'h00, wakeEnable} :
                     8'h00;

    // registered outputs
    wire next_irq  = |(next_irqStatus & irqEnable);
    wire next_wake = powerDown && clockFromRc && wakeEnable
                     && next_irqStatus[IRQ_DONE];

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            regRdData     <= 8'h00;
            dacCode       <= 10'h000;
            sampling      <= 1'b0;
            channelSelect <= 2'h0;
            wakeRequest   <= 1'b0;
            convBusy      <= 1'b0;
            irq           <= 1'b0;
        end
        else
        begin
            regRdData     <= regRead ? readMux : 8'h00;
            dacCode       <= next_sar;
            channelSelect <= wrControl ? regWrData[CTL_CHAN_MSB:CTL_CHAN_LSB] : chanSel;
            wakeRequest   <= next_wake;
            convBusy      <= (busyFlag || busySet) && !convDone;
            irq           <= next_irq;
            if (sampleStart)
            begin
                sampling <= 1'b1;
            end
            else if (sampleStop)
            begin
                sampling <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// *** adc_ctrl_assertions.sv ***
// port checker for the converter control block
`default_nettype none
module adc_ctrl_assertions
    import adc_ctrl_pkg::*;
#(
    parameter int MC_CLKS = 4
) (
    // clock and reset
    input wire logic       mclk,
    input wire logic       rstn,
    // register port
    input wire logic [2:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [7:0] regRdData,
    // converter
    input wire logic [9:0] dacCode,
    input wire logic       sampling,
    input wire logic [1:0] channelSelect,
    input wire logic       convBusy,
    // power
    input wire logic       powerDown,
    input wire logic       clockFromRc,
    input wire logic       wakeRequest
);
    timeunit 1ns;
    timeprecision 1ps;

    localparam int MC = MC_CLKS;
    logic [9:0] busyCnt;
    logic [9:0] sampleCnt;
    wire  [1:0] wrChan = regWrData[1:0];
    wire        ctlWrite = regWrite && (regAddr == OFS_CONTROL);

    // length of busy and sampling levels in clocks
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            busyCnt   <= 10'h000;
            sampleCnt <= 10'h000;
        end
        else
        begin
            busyCnt   <= convBusy ? busyCnt + 10'h001 : 10'h000;
            sampleCnt <= sampling ? sampleCnt + 10'h001 : 10'h000;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    sequence busyRise;
        $rose(convBusy);
    endsequence
    sequence sampleRise;
        $rose(sampling);
    endsequence

    AST_BUSY_LEN: assert property ($fell(convBusy) |-> busyCnt == 10'(51 * MC))
        else $error("busy length wrong");
    AST_SAMPLE_START: assert property (busyRise |-> ##MC sampleRise)
        else $error("sampling did not follow init");
    AST_SAMPLE_LEN: assert property ($fell(sampling) |-> sampleCnt == 10'(8 * MC))
        else $error("sampling length wrong");
    AST_SAMPLE_IN_BUSY: assert property (sampling |-> convBusy)
        else $error("sampling outside conversion");
    AST_FIRST_TRIAL: assert property ($fell(sampling) |-> dacCode == SAR_FIRST_TRIAL)
        else $error("first trial code wrong");
    AST_CHAN: assert property (ctlWrite |=> channelSelect == $past(wrChan))
        else $error("channel select not taken");
    AST_RD_ZERO: assert property (!$past(regRead) |-> regRdData == 8'h00)
        else $error("read data outside read cycle");
    AST_WAKE: assert property (wakeRequest |-> $past(powerDown) && $past(clockFromRc))
        else $error("wake without power-down on internal clock");
endmodule
`default_nettype wire

// *** adc_far_side.sv ***
// far side model: analog input, comparator and start pin
`default_nettype none
module adc_far_side #(
    parameter int MC = 4
) (
    // clock
    input  wire logic       mclk,
    // analog side
    input  wire logic [9:0] dacCode,
    input  wire logic [9:0] vin,
    output logic            compGreater,
    // start pin
    output logic            externalStartPin
);
    timeunit 1ns;
    timeprecision 1ps;

    assign compGreater = vin > dacCode;

    initial externalStartPin = 1'b1;

    // low two machine cycles, then high two
    task automatic pulse();
        @(posedge mclk);
        externalStartPin <= 1'b0;
        repeat (2 * MC) @(posedge mclk);
        externalStartPin <= 1'b1;
        repeat (2 * MC) @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// *** tb.sv ***
// self-checking bench for the converter control block
`default_nettype none
module tb
    import adc_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MC = 4;

    logic       mclk;
    logic       rstn;
    logic [2:0] regAddr;
    logic [7:0] regWrData;
    logic       regWrite;
    logic       regRead;
    logic [7:0] regRdData;
    logic       externalStartPin;
    logic       compGreater;
    logic [9:0] dacCode;
    logic       sampling;
    logic [1:0] channelSelect;
    logic       powerDown;
    logic       clockFromRc;
    logic       wakeRequest;
    logic       convBusy;
    logic       irq;
    logic [9:0] vin;
    logic [9:0] expRes;
    int         n_errors;
    int         cmp_count;
    int         cycles;

    sar_adc_conversion_control #(.MC_CLKS(MC)) uut (
        .mclk(mclk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .externalStartPin(externalStartPin), .compGreater(compGreater),
        .dacCode(dacCode), .sampling(sampling), .channelSelect(channelSelect),
        .powerDown(powerDown), .clockFromRc(clockFromRc), .wakeRequest(wakeRequest),
        .convBusy(convBusy), .irq(irq)
    );
    adc_far_side #(.MC(MC)) far (
        .mclk(mclk), .dacCode(dacCode), .vin(vin), .compGreater(compGreater),
        .externalStartPin(externalStartPin)
    );

    always #2 mclk = ~mclk;

    task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        regWrite  <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge mclk);
        regWrite  <= 1'b0;
    endtask

    task automatic rdChk(input logic [2:0] a, input logic [7:0] exp, input string what);
        @(posedge mclk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRead <= 1'b0;
        #1;
        check(what, {2'b00, regRdData}, {2'b00, exp});
    endtask

    task automatic waitBusy(input logic v, input int lim);
        int i;
        i = 0;
        while (convBusy !== v && i < lim)
        begin
            @(posedge mclk);
            #1;
            i++;
        end
        check("convBusy", {9'h000, convBusy}, {9'h000, v});
    endtask

    // successive approximation with strict comparison
    function automatic logic [9:0] sarExpect(input logic [9:0] v);
        logic [9:0] r;
        r = 10'h000;
        for (int b = 9; b >= 0; b--)
            if (v > (r | (10'h001 << b)))
                r = r | (10'h001 << b);
        return r;
    endfunction

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_errors++;
            results();
        end
    end

    initial
    begin
        mclk = 1'b0;
        rstn = 1'b0;
        regAddr = 3'h0;
        regWrData = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        powerDown = 1'b0;
        clockFromRc = 1'b0;
        vin = 10'h2A5;
        n_errors = 0;
        cmp_count = 0;
        cycles = 0;
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        rdChk(OFS_CONTROL, CONTROL_RESET, "control reset");
        rdChk(OFS_RESULT_HIGH, RESULT_RESET, "result reset");
        rdChk(OFS_IRQ_STATUS, 8'h00, "status reset");
        rdChk(3'h7, 8'h00, "unmapped");
        wr(OFS_IRQ_ENABLE, 8'h01);
        wr(OFS_WAKE_CFG, 8'h01);
        // software start on channel 2
        wr(OFS_CONTROL, 8'h0A);
        #1;
        check("channel", {8'h00, channelSelect}, 10'h002);
        waitBusy(1'b1, 2 * MC + 2);
        rdChk(OFS_CONTROL, 8'h0A, "busy read");
        waitBusy(1'b0, 51 * MC + 2);
        #8;
        check("irq", {9'h000, irq}, 10'h001);
        expRes = sarExpect(10'h2A5);
        rdChk(OFS_RESULT_HIGH, expRes[9:2], "result high");
        rdChk(OFS_CONTROL, {expRes[1:0], 6'h12}, "control done");
        @(posedge mclk);
        powerDown <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        check("wake off rc", {9'h000, wakeRequest}, 10'h000);
        @(posedge mclk);
        clockFromRc <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        check("wake on rc", {9'h000, wakeRequest}, 10'h001);
        @(posedge mclk);
        powerDown <= 1'b0;
        // clear done and status
        wr(OFS_CONTROL, 8'h02);
        wr(OFS_IRQ_CLEAR, 8'h03);
        rdChk(OFS_IRQ_STATUS, 8'h00, "status cleared");
        rdChk(OFS_CONTROL, 8'h02, "done cleared");
        check("irq cleared", {9'h000, irq}, 10'h000);
        // pin edge ignored without external enable
        far.pulse();
        repeat (3 * MC) @(posedge mclk);
        #1;
        check("no ext start", {9'h000, convBusy}, 10'h000);
        wr(OFS_CONTROL, 8'h22);
        vin <= 10'h3FF;
        far.pulse();
        waitBusy(1'b1, 2 * MC + 2);
        waitBusy(1'b0, 51 * MC + 2);
        expRes = sarExpect(10'h3FF);
        rdChk(OFS_RESULT_HIGH, expRes[9:2], "ext result");
        rdChk(OFS_CONTROL, {expRes[1:0], 6'h32}, "ext control");
        rdChk(OFS_IRQ_STATUS, 8'h03, "ext status");
        results();
    end
endmodule

bind sar_adc_conversion_control adc_ctrl_assertions #(.MC_CLKS(MC_CLKS)) chk (
    .mclk(mclk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .dacCode(dacCode), .sampling(sampling), .channelSelect(channelSelect),
    .convBusy(convBusy), .powerDown(powerDown), .clockFromRc(clockFromRc),
    .wakeRequest(wakeRequest)
);
`default_nettype wire
